// ==== include/inbound_window_pkg.sv ====
// constants for the inbound window decode and translation block
package inbound_window_pkg;
	localparam int NUM_WIN = 3;
	localparam int ADDR_W = 32;
	localparam int XLAT_W = 36;
	localparam int UPPER_W = XLAT_W - ADDR_W;
	localparam int LOW_BIT_WIN01 = 12;
	localparam int LOW_BIT_WIN2 = 8;
	localparam int SMALL_WIN_BIT = 10;
	localparam int FIX_LO_BIT = 8;
	localparam int FIX_HI_BIT = 9;
	localparam int CLAIM_DIS_BIT = 0;
	localparam int LANE_W = 8;
	localparam int LANES = 4;
	localparam logic [7:0] OFF_BASE0 = 8'h10;
	localparam logic [7:0] OFF_BASE_STRIDE = 8'h08;
	localparam logic [7:0] OFF_MAX_LATENCY = 8'h3f;
	localparam logic [7:0] OFF_MISC_WORD = 8'h3c;
	localparam int PIN_LANE = 1;
	localparam int MIN_GRANT_LANE = 2;
	localparam int MAX_LATENCY_LANE = 3;
	localparam logic [7:0] MAX_LATENCY_VALUE = 8'h00;
	localparam logic [7:0] MIN_GRANT_VALUE = 8'h00;
	localparam logic [7:0] PIN_DEFAULT = 8'h01;
	localparam logic [7:0] OFF_LIMIT0 = 8'h40;
	localparam logic [7:0] OFF_WIN_STRIDE = 8'h0c;
	localparam logic [7:0] OFF_TV_LOW = 8'h04;
	localparam logic [7:0] OFF_TV_HIGH = 8'h08;
	localparam logic [7:0] WORD_MASK = 8'hfc;
	localparam logic [31:0] LIMIT_RESET = 32'h00000000;
	localparam logic [31:0] TV_RESET = 32'h00000000;
	localparam logic [31:0] BASE_RESET = 32'h00000000;
endpackage

// ==== logic/window_decode.sv ====
// one inbound window: hit compare and address translation
`timescale 1ns/1ps
module window_decode #(
	parameter int LOW_BIT = 12,
	parameter bit SMALL_FIX = 1'b0
)(
	input wire logic [31:0] limit,
	input wire logic [31:0] base,
	input wire logic [31:0] tv_low,
	input wire logic [31:0] tv_high,
	input wire logic [31:0] addr,
	output logic hit,
	output logic [35:0] xlat
);
	wire logic [31:0] low_clear = {{(32 - LOW_BIT){1'b1}}, {LOW_BIT{1'b0}}};
	wire logic [31:0] hit_mask = limit & low_clear;
	// a window under 1 Kbyte has limit bit 9 or 8 set, so those bits sit inside the mask
	wire logic small_win = SMALL_FIX && (|limit[inbound_window_pkg::FIX_HI_BIT:inbound_window_pkg::FIX_LO_BIT]);
	wire logic [31:0] fix_clear = {22'h3fffff, ~{small_win, small_win}, 8'hff};
	// below 1 Kbyte the translate value's bits 9:8 are not used even if written
	wire logic [31:0] xlat_mask = hit_mask & fix_clear; // RULE11
	wire logic claim_off = limit[inbound_window_pkg::CLAIM_DIS_BIT];
	assign hit = (|hit_mask) && !claim_off && (((addr ^ base) & hit_mask) == 32'h00000000); // RULE14 RULE3
	assign xlat = {tv_high[inbound_window_pkg::UPPER_W-1:0], (tv_low & xlat_mask) | (addr & ~xlat_mask)}; // RULE5 RULE6 RULE7
endmodule

// ==== logic/inbound_window_translation.sv ====
// inbound address windows: registers, base gating, decode and translated request output
//
// Overview of operation
// RULE1 - windows 0 and 1: limit bits 31..12 decide which base bits are writable.
// RULE2 - an all-zero limit makes that window's base ignore every write.
// RULE3 - limit bit 0 set stops the window from claiming any cycle.
// RULE4 - window 2 gates base bits 31..8, giving 256 byte granularity.
// RULE5 - limit masks translation; low bits come from the incoming address.
// RULE6 - windows 0 and 1 translate value supplies internal bits 35..12.
// RULE7 - window 2 translate value supplies internal bits 35..8.
// RULE8 - a link request hitting a window goes out with its translated address.
// RULE9 - software aligns each translate value to its window size.
// RULE10 - software sets window 2 limit to ffffff00 for I/O space.
// RULE11 - window 2 below 1 Kbyte takes address bits 9..8 from the request.
// RULE12 - maximum latency register at 03f reads zero and ignores writes.
// RULE13 - an interrupt pin register names the legacy pin in use.
// RULE14 - hit when masked address equals masked base; translate masked value plus low bits.
`timescale 1ns/1ps
module inbound_window_translation #(
	parameter logic [7:0] PIN_VALUE = inbound_window_pkg::PIN_DEFAULT
)(
	input wire logic clk,
	input wire logic rst,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic cfg_from_link,
	input wire logic [7:0] cfg_addr,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output logic cfg_rvalid,
	input wire logic req_valid,
	input wire logic [31:0] req_addr,
	output logic out_valid,
	output logic [35:0] out_addr,
	output logic [1:0] out_window,
	output logic out_miss
);
	localparam int NW = inbound_window_pkg::NUM_WIN;

	logic [31:0] limit_ff [NW];
	logic [31:0] tv_low_ff [NW];
	logic [31:0] tv_high_ff [NW];
	logic [31:0] base_ff [NW];
	logic [31:0] cfg_rdata_ff;
	logic cfg_rvalid_ff;
	logic out_valid_ff;
	logic [35:0] out_addr_ff;
	logic [1:0] out_window_ff;
	logic out_miss_ff;

	wire logic [7:0] word_addr = cfg_addr & inbound_window_pkg::WORD_MASK;
	wire logic [31:0] be_mask = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};

	logic [NW-1:0] sel_limit;
	logic [NW-1:0] sel_tv_low;
	logic [NW-1:0] sel_tv_high;
	logic [NW-1:0] sel_base;
	logic [NW-1:0] win_hit;
	logic [35:0] win_xlat [NW];
	logic [31:0] base_view [NW];
	logic [31:0] rd_win [NW];

	////////////////////////////////////////////////////////////////////////////////
	// per-window registers and decoders
	genvar w;
	generate
		for (w = 0; w < NW; w++)
		begin : g_win
			localparam int LB = (w == 2) ? inbound_window_pkg::LOW_BIT_WIN2 : inbound_window_pkg::LOW_BIT_WIN01;
			localparam logic [7:0] OFF_L = 8'(inbound_window_pkg::OFF_LIMIT0 + w * inbound_window_pkg::OFF_WIN_STRIDE);
			localparam logic [7:0] OFF_B = 8'(inbound_window_pkg::OFF_BASE0 + w * inbound_window_pkg::OFF_BASE_STRIDE);
			wire logic [31:0] low_clear = {{(32 - LB){1'b1}}, {LB{1'b0}}};
			wire logic [31:0] gate = limit_ff[w] & low_clear;
			wire logic [31:0] nxt_limit = (limit_ff[w] & ~be_mask) | (cfg_wdata & be_mask);
			wire logic [31:0] nxt_tv_low = (tv_low_ff[w] & ~be_mask) | (cfg_wdata & be_mask);
			wire logic [31:0] nxt_tv_high = (tv_high_ff[w] & ~be_mask) | (cfg_wdata & be_mask);
			// only gated bits take write data; an all-zero gate leaves the base untouched
			wire logic [31:0] wr_bits = gate & be_mask; // RULE1 RULE4
			wire logic base_we = cfg_wr && sel_base[w] && cfg_from_link && (|gate); // RULE2
			wire logic [31:0] nxt_base = (base_ff[w] & ~wr_bits) | (cfg_wdata & wr_bits); // RULE1 RULE4
			assign sel_limit[w] = (word_addr == OFF_L);
			assign sel_tv_low[w] = (word_addr == 8'(OFF_L + inbound_window_pkg::OFF_TV_LOW));
			assign sel_tv_high[w] = (word_addr == 8'(OFF_L + inbound_window_pkg::OFF_TV_HIGH));
			assign sel_base[w] = (word_addr == OFF_B);
			// a limit bit cleared later hides the stored base bit, so it reads zero while that limit bit stays clear
			assign base_view[w] = base_ff[w] & gate; // RULE1 RULE4
			assign rd_win[w] = ({32{sel_limit[w]}} & limit_ff[w]) | ({32{sel_tv_low[w]}} & tv_low_ff[w])
				| ({32{sel_tv_high[w]}} & tv_high_ff[w]) | ({32{sel_base[w]}} & base_view[w]);

			always_ff @(posedge clk or posedge rst)
			begin
				if (rst)
				begin
					limit_ff[w] <= inbound_window_pkg::LIMIT_RESET;
					tv_low_ff[w] <= inbound_window_pkg::TV_RESET;
					tv_high_ff[w] <= inbound_window_pkg::TV_RESET;
					base_ff[w] <= inbound_window_pkg::BASE_RESET;
				end
				else
				begin
					if (cfg_wr && sel_limit[w])
						limit_ff[w] <= nxt_limit;
					if (cfg_wr && sel_tv_low[w])
						tv_low_ff[w] <= nxt_tv_low;
					if (cfg_wr && sel_tv_high[w])
						tv_high_ff[w] <= nxt_tv_high;
					if (base_we)
						base_ff[w] <= nxt_base;
				end
			end

			window_decode #(
				.LOW_BIT(LB),
				.SMALL_FIX(w == 2)
			) u_dec (
				.limit(limit_ff[w]),
				.base(base_view[w]),
				.tv_low(tv_low_ff[w]),
				.tv_high(tv_high_ff[w]),
				.addr(req_addr),
				.hit(win_hit[w]),
				.xlat(win_xlat[w])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// read mux; the misc word carries the fixed pin, grant and latency bytes
	wire logic sel_misc = (word_addr == inbound_window_pkg::OFF_MISC_WORD);
	wire logic [31:0] misc_word = {inbound_window_pkg::MAX_LATENCY_VALUE, inbound_window_pkg::MIN_GRANT_VALUE,
		PIN_VALUE, 8'h00}; // RULE12 RULE13
	wire logic [31:0] rd_all = rd_win[0] | rd_win[1] | rd_win[2] | ({32{sel_misc}} & misc_word);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cfg_rdata_ff <= 32'h00000000;
			cfg_rvalid_ff <= 1'b0;
		end
		else
		begin
			cfg_rvalid_ff <= cfg_rd;
			if (cfg_rd)
				cfg_rdata_ff <= rd_all;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// request translation; lowest-numbered hitting window wins overlaps
	wire logic any_hit = |win_hit;
	wire logic [1:0] nxt_window = win_hit[0] ? 2'h0 : (win_hit[1] ? 2'h1 : 2'h2);
	wire logic [35:0] nxt_out_addr = win_hit[0] ? win_xlat[0] : (win_hit[1] ? win_xlat[1] : win_xlat[2]);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			out_valid_ff <= 1'b0;
			out_addr_ff <= 36'h000000000;
			out_window_ff <= 2'h0;
			out_miss_ff <= 1'b0;
		end
		else
		begin
			out_valid_ff <= req_valid && any_hit; // RULE8
			out_miss_ff <= req_valid && !any_hit;
			if (req_valid && any_hit)
			begin
				out_addr_ff <= nxt_out_addr; // RULE8
				out_window_ff <= nxt_window;
			end
		end
	end

	assign cfg_rdata = cfg_rdata_ff;
	assign cfg_rvalid = cfg_rvalid_ff;
	assign out_valid = out_valid_ff;
	assign out_addr = out_addr_ff;
	assign out_window = out_window_ff;
	assign out_miss = out_miss_ff;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	chk_base_locked: assert property (@(posedge clk) disable iff (rst)
		(cfg_wr && sel_base[0] && (limit_ff[0][31:12] == 20'h00000)) |=> $stable(base_ff[0])) // RULE2
		else $error("base 0 changed while its limit was zero");
	chk_base_gate_low: assert property (@(posedge clk) disable iff (rst)
		(base_ff[0][11:0] == 12'h000) && (base_ff[1][11:0] == 12'h000)) // RULE1
		else $error("window 0 or 1 base shows bits below 12");
	chk_win2_gate: assert property (@(posedge clk) disable iff (rst)
		(cfg_wr && sel_base[2] && cfg_from_link && cfg_be[1] && limit_ff[2][8] && cfg_wdata[8])
		|=> base_view[2][8]) // RULE4
		else $error("window 2 base bit 8 not writable");
	chk_claim_off: assert property (@(posedge clk) disable iff (rst)
		(out_valid && out_window == 2'h0) |-> !$past(limit_ff[0][0])) // RULE3
		else $error("window 0 claimed while claim disabled");
	chk_low_passthru: assert property (@(posedge clk) disable iff (rst)
		(req_valid && win_hit[0]) |=> (out_addr[11:0] == $past(req_addr[11:0]))) // RULE5
		else $error("window 0 low bits not from request");
	chk_upper_bits: assert property (@(posedge clk) disable iff (rst)
		(req_valid && win_hit[1] && !win_hit[0]) |=> (out_addr[35:32] == $past(tv_high_ff[1][3:0]))) // RULE6
		else $error("window 1 upper bits not from translate value");
	chk_win2_upper: assert property (@(posedge clk) disable iff (rst)
		(req_valid && win_hit[2] && !win_hit[1] && !win_hit[0]) |=> (out_addr[35:32] == $past(tv_high_ff[2][3:0]))) // RULE7
		else $error("window 2 upper bits not from translate value");
	chk_small_win2: assert property (@(posedge clk) disable iff (rst)
		(req_valid && win_hit[2] && !win_hit[1] && !win_hit[0] && (|limit_ff[2][9:8]))
		|=> (out_addr[9:8] == $past(req_addr[9:8]))) // RULE11
		else $error("small window 2 translated bits 9:8");
	chk_req_output: assert property (@(posedge clk) disable iff (rst)
		req_valid |=> (out_valid != out_miss)) // RULE8
		else $error("request gave no single outcome");
	chk_maxlat_zero: assert property (@(posedge clk) disable iff (rst)
		(cfg_rd && word_addr == inbound_window_pkg::OFF_MISC_WORD) |=> (cfg_rvalid && cfg_rdata[31:24] == 8'h00)) // RULE12
		else $error("maximum latency byte not zero");
	chk_pin_value: assert property (@(posedge clk) disable iff (rst)
		(cfg_rd && word_addr == inbound_window_pkg::OFF_MISC_WORD) |=> (cfg_rdata[15:8] == PIN_VALUE)) // RULE13
		else $error("interrupt pin byte wrong");
endmodule

// ==== tb/link_host_model.sv ====
// link-side requester issuing inbound requests to the window block
`timescale 1ns/1ps
module link_host_model (
	input wire logic clk,
	output logic req_valid,
	output logic [31:0] req_addr
);
	initial
	begin
		req_valid = 1'b0;
		req_addr = 32'h00000000;
	end
	// after release the address turns to its inverse so a stale value never passes
	task automatic send(input logic [31:0] a);
		@(negedge clk);
		req_valid = 1'b1;
		req_addr = a;
		@(negedge clk);
		req_valid = 1'b0;
		req_addr = ~a;
	endtask
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the inbound window block
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cfg_wr = 1'b0;
	logic cfg_rd = 1'b0;
	logic cfg_from_link = 1'b0;
	logic [7:0] cfg_addr = 8'h00;
	logic [3:0] cfg_be = 4'h0;
	logic [31:0] cfg_wdata = 32'h00000000;
	logic [31:0] cfg_rdata;
	logic cfg_rvalid;
	logic req_valid;
	logic [31:0] req_addr;
	logic out_valid;
	logic [35:0] out_addr;
	logic [1:0] out_window;
	logic out_miss;
	int err_count = 0;
	int check_count = 0;
	logic [31:0] lim [3] = '{3{32'h0}};
	logic [31:0] bas [3] = '{3{32'h0}};
	logic [31:0] tvl [3] = '{3{32'h0}};
	logic [31:0] tvh [3] = '{3{32'h0}};
	always #2 clk = ~clk;
	inbound_window_translation DUT (.clk(clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
		.cfg_from_link(cfg_from_link), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .req_valid(req_valid), .req_addr(req_addr),
		.out_valid(out_valid), .out_addr(out_addr), .out_window(out_window), .out_miss(out_miss));
	link_host_model host (.clk(clk), .req_valid(req_valid), .req_addr(req_addr));
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] gate(input int w);
		return (w == 2) ? 32'hffffff00 : 32'hfffff000;
	endfunction
	task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
		check_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be, input logic lk);
		@(negedge clk);
		cfg_wr = 1'b1;
		cfg_addr = a;
		cfg_wdata = d;
		cfg_be = be;
		cfg_from_link = lk;
		@(negedge clk);
		cfg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(negedge clk);
		cfg_rd = 1'b1;
		cfg_addr = a;
		@(negedge clk);
		cfg_rd = 1'b0;
		chk("rvalid", 36'h1, {35'h0, cfg_rvalid});
		chk("rdata", {4'h0, exp}, {4'h0, cfg_rdata});
	endtask
	// sel 0 limit, 1 translate low, 2 translate high, 3 base
	task automatic put(input int w, input int sel, input logic [31:0] d, input logic [3:0] be, input logic lk);
		logic [31:0] bm;
		bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		if (sel == 3)
		begin
			wr(8'h10 + 8'(8 * w), d, be, lk);
			bm = bm & lim[w] & gate(w) & {32{lk}};
			bas[w] = (bas[w] & ~bm) | (d & bm);
		end
		else
		begin
			wr(8'h40 + 8'(12 * w + 4 * sel), d, be, lk);
			case (sel)
				0: lim[w] = (lim[w] & ~bm) | (d & bm);
				1: tvl[w] = (tvl[w] & ~bm) | (d & bm);
				default: tvh[w] = (tvh[w] & ~bm) | (d & bm);
			endcase
		end
	endtask
	task automatic req(input logic [31:0] a);
		logic [31:0] m;
		logic [31:0] xm;
		logic [35:0] xa;
		int hw;
		hw = -1;
		xa = 36'h0;
		// walk down so the lowest hitting window is the one kept
		for (int w = 2; w >= 0; w--)
		begin
			m = lim[w] & gate(w);
			xm = (w == 2 && (lim[w][9] || lim[w][8])) ? (m & 32'hfffffcff) : m;
			if (m != 0 && !lim[w][0] && ((a ^ bas[w]) & m) == 0)
			begin
				hw = w;
				xa = {tvh[w][3:0], (tvl[w] & xm) | (a & ~xm)};
			end
		end
		host.send(a);
		chk("out_miss", {35'h0, hw < 0}, {35'h0, out_miss});
		chk("out_valid", {35'h0, hw >= 0}, {35'h0, out_valid});
		if (hw >= 0)
		begin
			chk("out_window", 36'(hw), {34'h0, out_window});
			chk("out_addr", xa, out_addr);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		#20000;
		err_count++;
		report_and_stop();
	end
	initial
	begin
		logic [31:0] l;
		int w;
		void'($urandom(32'h3645f702));
		repeat (12) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		rd(8'h3c, {16'h0000, inbound_window_pkg::PIN_DEFAULT, 8'h00});
		wr(8'h3c, 32'hffffffff, 4'hf, 1'b1);
		rd(8'h3c, {16'h0000, inbound_window_pkg::PIN_DEFAULT, 8'h00});
		rd(8'hf0, 32'h0);
		put(0, 3, 32'hffffffff, 4'hf, 1'b1);
		rd(8'h10, 32'h0);
		req($urandom);
		for (int i = 0; i < 18; i++)
		begin
			w = i % 3;
			l = 32'hffffffff << ((i == 2) ? 8 : $urandom_range(w == 2 ? 8 : 12, 20));
			l[0] = (i % 5 == 4);
			put(w, 0, l, 4'hf, 1'($urandom));
			put(w, 1, $urandom & l & gate(w), 4'hf, 1'($urandom));
			put(w, 2, $urandom, 4'hf, 1'b0);
			put(w, 3, $urandom, 4'($urandom), 1'b0);
			put(w, 3, $urandom, 4'($urandom_range(1, 15)), 1'b1);
			rd(8'h10 + 8'(8 * w), bas[w] & lim[w] & gate(w));
			rd(8'h40 + 8'(12 * w), lim[w]);
			req((bas[w] & l & gate(w)) | ($urandom & ~(l & gate(w))));
			req($urandom);
		end
		report_and_stop();
	end
endmodule
